// *** core/fifo_flag_map.svh ***
// Register offsets, field positions, reset values and sizes for the FIFO flag block
`ifndef FIFO_FLAG_MAP_SVH
`define FIFO_FLAG_MAP_SVH

// Byte addresses of the word registers
`define FF_EMPTY_OFS_ADDR   12'h000
`define FF_FULL_OFS_ADDR    12'h004
`define FF_STATUS_ADDR      12'h008
`define FF_INT_EN_ADDR      12'h00c
`define FF_INT_CLR_ADDR     12'h010
`define FF_LEVEL_ADDR       12'h014

// Storage shape
`define FF_DEPTH            131072
`define FF_WORD_W           9

// Offset register defaults (words)
`define FF_EMPTY_OFS_RST    7
`define FF_FULL_OFS_RST     7

// Event bit positions in status, enable and clear
`define FF_EV_FULL          0
`define FF_EV_EMPTY         1
`define FF_EV_ALMOST_FULL   2
`define FF_EV_ALMOST_EMPTY  3
`define FF_EV_WR_REFUSED    4
`define FF_EV_RD_REFUSED    5
`define FF_EV_W             6

// Flag positions in the level register, above the count
`define FF_LEVEL_FLAG_LSB   24
`endif

// *** core/fifo_flag_pkg.sv ***
// Types shared by the FIFO flag block
package fifo_flag_pkg;

    // The four active-low status indicators
    typedef struct packed {
        logic full_flag_n;          // Low when storage is full
        logic almost_full_flag_n;   // Low within m of full
        logic almost_empty_flag_n;  // Low within n of empty
        logic empty_flag_n;         // Low when nothing unread
    } flag_type;

    // Sticky events, bit 0 is the full event
    typedef struct packed {
        logic rd_refused;           // Read attempted while empty
        logic wr_refused;           // Write attempted while full
        logic almost_empty;         // Almost-empty became active
        logic almost_full;          // Almost-full became active
        logic empty;                // Empty became active
        logic full;                 // Full became active
    } event_type;

    // Write request from the writing controller
    typedef struct packed {
        logic       en;             // Write enable, active high
        logic [8:0] data;           // Word to store
    } write_req_type;

endpackage

// *** core/fifo_status_flag_logic.sv ***
// FIFO storage with full, empty and programmable almost flags, APB control
`timescale 1ns/1ps
`include "fifo_flag_map.svh"
module fifo_status_flag_logic #(
    parameter int DEPTH = `FF_DEPTH,        // Words of storage
    parameter int OFS_W = 17                // Width of each offset
) (
    input  wire logic                          pclk,      // Clock, read and write side
    input  wire logic                          presetn,   // Async reset, active low
    input  wire logic                          psel,      // APB select
    input  wire logic                          penable,   // APB access phase
    input  wire logic                          pwrite,    // APB direction
    input  wire logic [11:0]                   paddr,     // APB byte address
    input  wire logic [31:0]                   pwdata,    // APB write data
    output logic                               pready,    // APB ready
    output logic [31:0]                        prdata,    // APB read data
    output logic                               pslverr,   // APB error, unmapped
    input  wire fifo_flag_pkg::write_req_type  wr_req,    // Write enable and word
    input  wire logic                          rd_en,     // Read enable, active high
    output logic [`FF_WORD_W-1:0]              rd_data,   // Last word read
    output fifo_flag_pkg::flag_type            flags,     // Four active-low flags
    output logic                               irq        // Level interrupt
);
    localparam int AW = $clog2(DEPTH);        // Pointer width
    localparam int CW = $clog2(DEPTH + 1);    // Count width
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [`FF_WORD_W-1:0] mem [DEPTH];       // Storage array
    logic [AW-1:0]         wr_ptr;            // Next location to write
    logic [AW-1:0]         rd_ptr;            // Next location to read
    logic [CW-1:0]         count;             // Unread words
    logic [CW-1:0]         next_count;        // Count after this edge
    logic [OFS_W-1:0]      empty_ofs;         // Offset n
    logic [OFS_W-1:0]      full_ofs;          // Offset m
    logic [OFS_W-1:0]      next_empty_ofs;    // n after this edge
    logic [OFS_W-1:0]      next_full_ofs;     // m after this edge
    logic [CW-1:0]         af_level;          // Depth minus m
    fifo_flag_pkg::flag_type  next_flags;     // Flags after this edge
    fifo_flag_pkg::event_type status;         // Sticky events
    fifo_flag_pkg::event_type int_en;         // Interrupt enables
    fifo_flag_pkg::event_type raise;          // Events this cycle
    logic                  wr_ok;             // Write accepted
    logic                  rd_ok;             // Read accepted
    logic                  apb_wr;            // Completed APB write
    logic                  hit;               // Address is mapped

    // Accept requests only while the boundary flag allows them
    always_comb begin
        wr_ok = wr_req.en && flags.full_flag_n;
        rd_ok = rd_en && flags.empty_flag_n;
    end

    // Count after this edge, both sides may move at once
    always_comb begin
        next_count = count;
        if (wr_ok && !rd_ok) begin
            next_count = CW'(count + 1'b1);
        end else if (rd_ok && !wr_ok) begin
            next_count = CW'(count - 1'b1);
        end
    end

    // Write stores a word and advances the write pointer
    always_ff @(posedge pclk) begin
        if (wr_ok) begin
            mem[wr_ptr] <= wr_req.data;
        end
    end

    // Write pointer, wraps at the last location
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
        end else if (wr_ok) begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : AW'(wr_ptr + 1'b1);
        end
    end

    // Read pointer and read data; an empty FIFO keeps the last word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr  <= '0;
            rd_data <= '0;
        end else if (rd_ok) begin
            rd_data <= mem[rd_ptr];
            rd_ptr  <= (rd_ptr == LAST_PTR) ? '0 : AW'(rd_ptr + 1'b1);
        end
    end

    // Unread word count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Flag decode from the coming count and coming offsets
    always_comb begin
        af_level = CW'(FULL_CNT - CW'(next_full_ofs));
        next_flags.full_flag_n         = (next_count != FULL_CNT);
        next_flags.empty_flag_n        = (next_count != '0);
        next_flags.almost_empty_flag_n = (next_count > CW'(next_empty_ofs));
        next_flags.almost_full_flag_n  = (next_count < af_level);
    end

    // One flop per flag; the single clock serves both sides
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '{full_flag_n: 1'b1, almost_full_flag_n: 1'b1,
                       almost_empty_flag_n: 1'b0, empty_flag_n: 1'b0};
        end else begin
            flags <= next_flags;
        end
    end

    // APB decode
    always_comb begin
        apb_wr = psel && penable && pready && pwrite;
        hit = (paddr == `FF_EMPTY_OFS_ADDR) || (paddr == `FF_FULL_OFS_ADDR) ||
              (paddr == `FF_STATUS_ADDR) || (paddr == `FF_INT_EN_ADDR) ||
              (paddr == `FF_INT_CLR_ADDR) || (paddr == `FF_LEVEL_ADDR);
    end

    // Coming offset values, a completed write replaces them
    always_comb begin
        next_empty_ofs = empty_ofs;
        next_full_ofs  = full_ofs;
        if (apb_wr && paddr == `FF_EMPTY_OFS_ADDR) begin
            next_empty_ofs = pwdata[OFS_W-1:0];
        end
        if (apb_wr && paddr == `FF_FULL_OFS_ADDR) begin
            next_full_ofs = pwdata[OFS_W-1:0];
        end
    end

    // Offset registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_ofs <= OFS_W'(`FF_EMPTY_OFS_RST);
            full_ofs  <= OFS_W'(`FF_FULL_OFS_RST);
        end else begin
            empty_ofs <= next_empty_ofs;
            full_ofs  <= next_full_ofs;
        end
    end

    // Interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en <= '0;
        end else if (apb_wr && paddr == `FF_INT_EN_ADDR) begin
            int_en <= pwdata[`FF_EV_W-1:0];
        end
    end

    // Events: flag falling edges and refused requests
    always_comb begin
        raise.full         = flags.full_flag_n && !next_flags.full_flag_n;
        raise.empty        = flags.empty_flag_n && !next_flags.empty_flag_n;
        raise.almost_full  = flags.almost_full_flag_n && !next_flags.almost_full_flag_n;
        raise.almost_empty = flags.almost_empty_flag_n && !next_flags.almost_empty_flag_n;
        raise.wr_refused   = wr_req.en && !flags.full_flag_n;
        raise.rd_refused   = rd_en && !flags.empty_flag_n;
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (apb_wr && paddr == `FF_INT_CLR_ADDR) begin
            status <= (status & ~pwdata[`FF_EV_W-1:0]) | raise;
        end else begin
            status <= status | raise;
        end
    end

    // Interrupt level, one cycle behind the status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & int_en);
        end
    end

    // APB answer: ready in the access cycle, data caught at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `FF_EMPTY_OFS_ADDR: prdata <= 32'(empty_ofs);
                    `FF_FULL_OFS_ADDR:  prdata <= 32'(full_ofs);
                    `FF_STATUS_ADDR:    prdata <= 32'(status);
                    `FF_INT_EN_ADDR:    prdata <= 32'(int_en);
                    `FF_LEVEL_ADDR: begin
                        prdata <= 32'(count);
                        prdata[`FF_LEVEL_FLAG_LSB+:4] <= flags;
                    end
                    default:            prdata <= '0;
                endcase
            end
        end
    end

    // Checks on the flag, event, interrupt, offset and APB behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    full_at_depth_a: assert property (
        flags.full_flag_n == (count != FULL_CNT)
        && (count != FULL_CNT || !flags.almost_full_flag_n))
        else $error("full flag disagrees with count");

    write_refused_a: assert property (
        (wr_req.en && !flags.full_flag_n) |=> $stable(wr_ptr) && count <= $past(count))
        else $error("write taken while full");

    full_tracks_count_a: assert property (
        $changed(flags.full_flag_n) |-> $changed(count))
        else $error("full flag moved without a count change");

    empty_at_zero_a: assert property (
        flags.empty_flag_n == (count != '0)
        && (count != '0 || !flags.almost_empty_flag_n))
        else $error("empty flag disagrees with count");

    read_refused_a: assert property (
        (rd_en && !flags.empty_flag_n) |=> $stable(rd_ptr) && $stable(rd_data))
        else $error("read taken while empty");

    empty_tracks_count_a: assert property (
        $changed(flags.empty_flag_n) |-> $changed(count))
        else $error("empty flag moved without a count change");

    almost_empty_level_a: assert property (
        flags.almost_empty_flag_n == (count > CW'(empty_ofs)))
        else $error("almost-empty disagrees with n");

    almost_full_level_a: assert property (
        flags.almost_full_flag_n == (count < CW'(FULL_CNT - CW'(full_ofs))))
        else $error("almost-full disagrees with m");

    low_band_a: assert property (
        (count >= 1 && count <= CW'(empty_ofs) && count < CW'(FULL_CNT - CW'(full_ofs)))
        |-> flags == 4'b1101)
        else $error("low band flags wrong");

    mid_band_a: assert property (
        (count > CW'(empty_ofs) && count < CW'(FULL_CNT - CW'(full_ofs)))
        |-> flags == 4'b1111)
        else $error("middle band flags wrong");

    top_band_a: assert property (
        (count >= CW'(FULL_CNT - CW'(full_ofs)) && count < FULL_CNT
         && count > CW'(empty_ofs)) |-> flags == 4'b1011)
        else $error("top band flags wrong");

    // An accepted write always moves the write pointer
    write_taken_a: assert property (
        (wr_req.en && flags.full_flag_n) |=> (wr_ptr != $past(wr_ptr)))
        else $error("accepted write left the pointer");

    // An accepted read always moves the read pointer
    read_taken_a: assert property (
        (rd_en && flags.empty_flag_n) |=> (rd_ptr != $past(rd_ptr)))
        else $error("accepted read left the pointer");

    // A write against a full store is recorded as an event
    wr_refused_seen_a: assert property (
        (wr_req.en && !flags.full_flag_n) |=> status.wr_refused)
        else $error("refused write not recorded");

    // A read against an empty store is recorded as an event
    rd_refused_seen_a: assert property (
        (rd_en && !flags.empty_flag_n) |=> status.rd_refused)
        else $error("refused read not recorded");

    // Status bits only drop when software clears them
    status_sticky_a: assert property (
        !(apb_wr && paddr == `FF_INT_CLR_ADDR) |=> (($past(status) & ~status) == 6'h00))
        else $error("status bit dropped without a clear");

    // An event in the clear cycle survives the clear
    set_beats_clear_a: assert property (
        (apb_wr && paddr == `FF_INT_CLR_ADDR) |=> ((status & $past(raise)) == $past(raise)))
        else $error("clear swallowed a new event");

    // Interrupt follows enabled status one cycle late
    irq_level_a: assert property (
        irq == (|($past(status) & $past(int_en))))
        else $error("interrupt level disagrees with status");

    // Every setup cycle is answered in the next cycle
    access_ready_a: assert property (
        (psel && !penable) |=> pready)
        else $error("access cycle without ready");

    // Unmapped addresses answer with an error
    unmapped_error_a: assert property (
        (psel && !penable && !hit) |=> (pready && pslverr))
        else $error("unmapped access without error");

    // A completed write loads the empty offset
    empty_ofs_load_a: assert property (
        (apb_wr && paddr == `FF_EMPTY_OFS_ADDR) |=> (empty_ofs == OFS_W'($past(pwdata))))
        else $error("empty offset not loaded");

    // A completed write loads the full offset
    full_ofs_load_a: assert property (
        (apb_wr && paddr == `FF_FULL_OFS_ADDR) |=> (full_ofs == OFS_W'($past(pwdata))))
        else $error("full offset not loaded");

    fill_to_full_c: cover property (!flags.full_flag_n);
    drain_from_full_c: cover property (!flags.full_flag_n ##[1:1000] !flags.empty_flag_n);
    write_refused_c: cover property (wr_req.en && !flags.full_flag_n);
    irq_raised_c: cover property ($rose(irq));
    status_clear_c: cover property (apb_wr && paddr == `FF_INT_CLR_ADDR);

endmodule

// *** testbench/fifo_stream_partner.sv ***
// Writing and reading controller model that faces the FIFO flag block
`timescale 1ns/1ps
module fifo_stream_partner (
    input  wire logic                    pclk,     // Shared write and read clock
    input  wire logic [8:0]              rd_data,  // Word returned by the FIFO
    output fifo_flag_pkg::write_req_type wr_req,   // Write enable and word
    output logic                         rd_en     // Read enable, active high
);
    // Both controllers start idle
    initial begin
        wr_req = '0;
        rd_en  = 1'b0;
    end

    // Presents k consecutive words, one per cycle, called just after a rising edge
    task automatic write_burst(input int k, input logic [8:0] base);
        for (int i = 0; i < k; i++) begin
            wr_req <= '{en: 1'b1, data: base + 9'(i)};
            @(posedge pclk);
        end
        wr_req.en <= 1'b0;
    endtask

    // Asks for one word and returns what the FIFO shows a cycle later
    task automatic read_one(output logic [8:0] got);
        rd_en <= 1'b1;
        @(posedge pclk);
        rd_en <= 1'b0;
        @(negedge pclk);
        got = rd_data;
        @(posedge pclk);
    endtask
endmodule

// *** testbench/fifo_status_flag_logic_tb.sv ***
// Self-checking bench for the FIFO flag block and its stream partner
`timescale 1ns/1ps
`include "fifo_flag_map.svh"
module fifo_status_flag_logic_tb;
    localparam int DEPTH = 16;                    // Shortened storage for simulation
    typedef struct packed {
        logic [4:0] count;                        // Fill level to reach
        logic [3:0] fl;                           // Flags expected at that level
    } row_type;
    logic                         pclk, presetn;  // Clock and reset
    logic                         psel, penable;  // APB handshake
    logic                         pwrite, pready; // APB direction and ready
    logic                         pslverr, err;   // APB error and its capture
    logic [11:0]                  paddr;          // APB address
    logic [31:0]                  pwdata, prdata; // APB data
    logic [31:0]                  rword;          // Last word read over APB
    logic                         rd_en, irq;     // Read request and interrupt
    logic [8:0]                   rd_data, got;   // Read word and its capture
    fifo_flag_pkg::write_req_type wr_req;         // Write request
    fifo_flag_pkg::flag_type      flags;          // Four active-low flags
    int                           fails, cmp_count, cnt; // Counters and fill level
    row_type rows [6] = '{'{5'd1, 4'hd}, '{5'd7, 4'hd}, '{5'd8, 4'hf},
                          '{5'd9, 4'hb}, '{5'd15, 4'hb}, '{5'd16, 4'h3}};

    fifo_status_flag_logic #(.DEPTH(DEPTH)) i_fifo_status_flag_logic (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wr_req(wr_req), .rd_en(rd_en), .rd_data(rd_data),
        .flags(flags), .irq(irq));

    fifo_stream_partner i_fifo_stream_partner (
        .pclk(pclk), .rd_data(rd_data), .wr_req(wr_req), .rd_en(rd_en));

    // Ends the run with the verdict
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Counts a comparison and reports a mismatch
    task automatic check(input logic [31:0] val, input logic [31:0] exp);
        cmp_count++;
        if (val !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask

    // One APB transfer, waiting for pready under a bound, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (w = 0; w < 20; w++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (w == 20) begin
            fails++;
            give_verdict();
        end
        rword = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Register read compared under a mask
    task automatic rreg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rword & m, exp);
    endtask

    // Flags compared at the falling edge, returns after the next rising edge
    task automatic fchk(input logic [3:0] exp);
        @(negedge pclk);
        check(32'(flags), 32'(exp));
        @(posedge pclk);
    endtask

    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Main sequence
    initial begin
        fails     = 0;
        cmp_count = 0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        fchk(4'hc);
        rreg(`FF_EMPTY_OFS_ADDR, 32'hffff_ffff, 32'h0000_0007);
        rreg(`FF_FULL_OFS_ADDR, 32'hffff_ffff, 32'h0000_0007);
        // Fill through every band of the flag table
        cnt = 0;
        foreach (rows[i]) begin
            i_fifo_stream_partner.write_burst(int'(rows[i].count) - cnt, 9'(cnt));
            cnt = int'(rows[i].count);
            fchk(rows[i].fl);
            rreg(`FF_LEVEL_ADDR, 32'h0003_ffff, 32'(cnt));
        end
        // Writes while full are refused and raise the refused event
        i_fifo_stream_partner.write_burst(2, 9'h1aa);
        fchk(4'h3);
        rreg(`FF_LEVEL_ADDR, 32'h0003_ffff, 32'h0000_0010);
        rreg(`FF_STATUS_ADDR, 32'h0000_0015, 32'h0000_0015);
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, `FF_INT_EN_ADDR, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(32'(irq), 32'h0000_0001);
        @(posedge pclk);
        apb(1'b1, `FF_INT_CLR_ADDR, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(32'(irq), 32'h0000_0000);
        @(posedge pclk);
        // Drain in order; the refused words must never appear
        for (int i = 0; i < DEPTH; i++) begin
            i_fifo_stream_partner.read_one(got);
            check(32'(got), 32'(i));
        end
        fchk(4'hc);
        // Read while empty keeps the last word and the level
        i_fifo_stream_partner.read_one(got);
        check(32'(got), 32'h0000_000f);
        rreg(`FF_LEVEL_ADDR, 32'h0003_ffff, 32'h0000_0000);
        rreg(`FF_STATUS_ADDR, 32'h0000_003f, 32'h0000_002f);
        // Programmed offsets move both almost thresholds
        apb(1'b1, `FF_EMPTY_OFS_ADDR, 32'h0000_0002);
        apb(1'b1, `FF_FULL_OFS_ADDR, 32'h0000_0003);
        rreg(`FF_EMPTY_OFS_ADDR, 32'hffff_ffff, 32'h0000_0002);
        rreg(`FF_FULL_OFS_ADDR, 32'hffff_ffff, 32'h0000_0003);
        i_fifo_stream_partner.write_burst(2, 9'h000);
        fchk(4'hd);
        i_fifo_stream_partner.write_burst(1, 9'h002);
        fchk(4'hf);
        i_fifo_stream_partner.write_burst(9, 9'h003);
        fchk(4'hf);
        i_fifo_stream_partner.write_burst(1, 9'h00c);
        fchk(4'hb);
        // Unmapped address answers with an error and zero data
        apb(1'b0, 12'h020, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        check(rword, 32'h0000_0000);
        // Reset in mid-run returns the empty state and the default empty offset
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        fchk(4'hc);
        rreg(`FF_EMPTY_OFS_ADDR, 32'hffff_ffff, 32'h0000_0007);
        give_verdict();
    end
endmodule
